// File: rtl/servo_cond_map.vh
// Register offsets, field positions, reset values and limits of the block.
`ifndef SERVO_COND_MAP_VH
`define SERVO_COND_MAP_VH

// Register byte offsets.
`define ADDR_ZERO_RANGE    8'h00
`define ADDR_OVS_LEVEL     8'h04
`define ADDR_CONFIG        8'h08
`define ADDR_LIVE_STATUS   8'h0C
`define ADDR_IRQ_STATUS    8'h10
`define ADDR_IRQ_ENABLE    8'h14
`define ADDR_IRQ_CLEAR     8'h18
`define ADDR_ALARM_LOG     8'h1C
`define ADDR_OVS_EFFECTIVE 8'h20

// Configuration register fields.
`define CFG_HOME_SEL       0
`define CFG_SERVO_ON_SEL   1
`define CFG_UNDERVOLT_SEL  2
`define CFG_LOG_ERASE_SEL  3
`define CFG_WIDTH          4

// Live status fields.
`define LIVE_ZERO_SPEED    0
`define LIVE_OVERSPEED     1
`define LIVE_Z_PASSED      2
`define LIVE_HOME_ALLOWED  3

// Event, enable, clear and alarm log fields share one layout.
`define EVT_OVERSPEED      0
`define EVT_SERVO_ON_MAIN  1
`define EVT_BUS_DROP       2
`define EVT_LOG_ERASED     3
`define EVT_WIDTH          4

// Speed figures in r/min, then the overspeed percent and its base.
`define ZERO_RANGE_RESET   16'h0032
`define ZERO_RANGE_MAX     16'h2710
`define ZERO_HYSTERESIS    17'h00014
`define UNDERVOLT_SPEED    16'h0032
`define OVS_LEVEL_RESET    16'h0000
`define OVS_PERCENT        120
`define PERCENT_BASE       100

`define CFG_RESET          4'h0
`define EVT_RESET          4'h0

`endif

// File: rtl/servo_speed_alarm_condition_logic.v
// Zero-speed, overspeed, home condition, power alarms and log erase logic.
//
// Contract
// - Zero-speed flag within programmable range, 50 default.
// - Zero-speed comparison uses 20 r/min hysteresis.
// - Overspeed level clamped to 120% maximum speed.
// - Overspeed level zero means 120% maximum.
// - Home select 0 needs Z-phase since power-on.
// - Servo-on alarm: select 0 ready+servo, 1 servo.
// - Undervoltage select 0 always raises bus drop.
// - Select 1: slow gives servo-on alarm, else drop.
// - Log erase select erases at next power-on.
// - Erase select clears itself after erasing.
`timescale 1ns/1ps
`include "servo_cond_map.vh"

module servo_speed_alarm_condition_logic
#(
   parameter MAX_SPEED = 16'h0BB8
)
(
   // Clock and reset.
   input  wire        clk_sys,
   input  wire        reset_n,
   // Register port.
   input  wire [7:0]  reg_addr,
   input  wire [31:0] reg_wdata,
   input  wire        reg_write,
   input  wire        reg_read,
   output reg  [31:0] reg_rdata,
   // Motor and controller status.
   input  wire [15:0] motor_speed,
   input  wire        encoder_z_pulse,
   input  wire        ready_on_cmd,
   input  wire        servo_on_cmd,
   input  wire        main_circuit_on,
   input  wire        bus_undervoltage,
   input  wire        power_on_pulse,
   // Condition outputs.
   output reg         zero_speed_flag,
   output reg         overspeed_alarm,
   output reg         servo_on_main_off_alarm,
   output reg         bus_voltage_drop_alarm,
   output reg         home_position_allowed,
   output reg         alarm_log_erase,
   output reg         irq
);

   // The 120% ceiling is fixed by the motor, so it is built once here.
   localparam [31:0] OVS_CEIL_WIDE = MAX_SPEED * `OVS_PERCENT / `PERCENT_BASE;
   localparam [15:0] OVS_CEIL = OVS_CEIL_WIDE[15:0];

   function [15:0] saturate;
      input [15:0] value;
      input [15:0] limit;
      begin
         saturate = (value > limit) ? limit : value;
      end
   endfunction

   reg  [15:0]           zero_range_reg;
   reg  [15:0]           ovs_level_reg;
   reg  [`CFG_WIDTH-1:0] config_reg;
   reg  [`EVT_WIDTH-1:0] irq_status_reg;
   reg  [`EVT_WIDTH-1:0] irq_enable_reg;
   reg  [`EVT_WIDTH-1:0] alarm_log_reg;
   reg                   z_passed_reg;

   reg  [`EVT_WIDTH-1:0] irq_status_next;
   reg  [`EVT_WIDTH-1:0] alarm_log_next;
   reg  [`EVT_WIDTH-1:0] events;
   reg  [`CFG_WIDTH-1:0] config_next;
   reg                   zero_speed_next;
   reg                   servo_on_alarm_next;
   reg                   bus_drop_next;
   reg                   erase_now;
   reg  [31:0]           rdata_next;

   wire [15:0] ovs_threshold;
   wire [16:0] zero_release;
   wire        overspeed_next;
   wire        home_allowed_next;

   // A zero level selects the ceiling; anything above it is clamped.
   assign ovs_threshold = (ovs_level_reg == `OVS_LEVEL_RESET) ? OVS_CEIL :
                          saturate(ovs_level_reg, OVS_CEIL);
   assign overspeed_next = (motor_speed > ovs_threshold);
   assign zero_release = {1'b0, zero_range_reg} + `ZERO_HYSTERESIS;
   assign home_allowed_next = config_reg[`CFG_HOME_SEL] |
                              z_passed_reg;

   always @*
   begin
      // Between the range and range plus hysteresis the flag holds.
      zero_speed_next = zero_speed_flag;
      if (motor_speed <= zero_range_reg)
         zero_speed_next = 1'b1;
      else if ({1'b0, motor_speed} > zero_release)
         zero_speed_next = 1'b0;

      servo_on_alarm_next = 1'b0;
      bus_drop_next = 1'b0;
      if (!main_circuit_on)
      begin
         if (config_reg[`CFG_SERVO_ON_SEL])
            servo_on_alarm_next = servo_on_cmd;
         else
            servo_on_alarm_next = servo_on_cmd & ready_on_cmd;
      end
      if (bus_undervoltage)
      begin
         if (!config_reg[`CFG_UNDERVOLT_SEL])
            bus_drop_next = 1'b1;
         else if (motor_speed <= `UNDERVOLT_SPEED)
            servo_on_alarm_next = 1'b1;
         else
            bus_drop_next = 1'b1;
      end

      // The erase waits for the next power-on, never the write itself.
      erase_now = power_on_pulse & config_reg[`CFG_LOG_ERASE_SEL];

      events = {`EVT_WIDTH{1'b0}};
      events[`EVT_OVERSPEED] = overspeed_next;
      events[`EVT_SERVO_ON_MAIN] = servo_on_alarm_next;
      events[`EVT_BUS_DROP] = bus_drop_next;
      events[`EVT_LOG_ERASED] = erase_now;

      // Set wins over clear so no event is lost in the clearing cycle.
      irq_status_next = irq_status_reg;
      if (reg_write && reg_addr == `ADDR_IRQ_CLEAR)
         irq_status_next = irq_status_reg & ~reg_wdata[`EVT_WIDTH-1:0];
      irq_status_next = irq_status_next | events;

      // The log records alarms only; an erase in the same cycle wins so
      // that the history starts empty after power-on.
      alarm_log_next = alarm_log_reg | {1'b0, events[`EVT_WIDTH-2:0]};
      if (erase_now)
         alarm_log_next = {`EVT_WIDTH{1'b0}};

      config_next = config_reg;
      if (reg_write && reg_addr == `ADDR_CONFIG)
         config_next = reg_wdata[`CFG_WIDTH-1:0];
      if (erase_now)
         config_next[`CFG_LOG_ERASE_SEL] = 1'b0;

      rdata_next = 32'h00000000;
      if (reg_read)
      begin
         case (reg_addr)
            `ADDR_ZERO_RANGE:    rdata_next[15:0] = zero_range_reg;
            `ADDR_OVS_LEVEL:     rdata_next[15:0] = ovs_level_reg;
            `ADDR_CONFIG:        rdata_next[`CFG_WIDTH-1:0] = config_reg;
            `ADDR_LIVE_STATUS:
            begin
               rdata_next[`LIVE_ZERO_SPEED] = zero_speed_flag;
               rdata_next[`LIVE_OVERSPEED] = overspeed_alarm;
               rdata_next[`LIVE_Z_PASSED] = z_passed_reg;
               rdata_next[`LIVE_HOME_ALLOWED] = home_position_allowed;
            end
            `ADDR_IRQ_STATUS:    rdata_next[`EVT_WIDTH-1:0] = irq_status_reg;
            `ADDR_IRQ_ENABLE:    rdata_next[`EVT_WIDTH-1:0] = irq_enable_reg;
            `ADDR_ALARM_LOG:     rdata_next[`EVT_WIDTH-1:0] = alarm_log_reg;
            `ADDR_OVS_EFFECTIVE: rdata_next[15:0] = ovs_threshold;
            default:             rdata_next = 32'h00000000;
         endcase
      end
   end

   always @(posedge clk_sys or negedge reset_n)
   begin
      if (!reset_n)
      begin
         zero_range_reg          <= `ZERO_RANGE_RESET;
         ovs_level_reg           <= `OVS_LEVEL_RESET;
         config_reg              <= `CFG_RESET;
         irq_status_reg          <= `EVT_RESET;
         irq_enable_reg          <= `EVT_RESET;
         alarm_log_reg           <= `EVT_RESET;
         z_passed_reg            <= 1'b0;
         reg_rdata               <= 32'h00000000;
         zero_speed_flag         <= 1'b0;
         overspeed_alarm         <= 1'b0;
         servo_on_main_off_alarm <= 1'b0;
         bus_voltage_drop_alarm  <= 1'b0;
         home_position_allowed   <= 1'b0;
         alarm_log_erase         <= 1'b0;
         irq                     <= 1'b0;
      end
      else
      begin
         if (reg_write && reg_addr == `ADDR_ZERO_RANGE)
            zero_range_reg <= saturate(reg_wdata[15:0],
                                       `ZERO_RANGE_MAX);
         if (reg_write && reg_addr == `ADDR_OVS_LEVEL)
            ovs_level_reg <= reg_wdata[15:0];
         if (reg_write && reg_addr == `ADDR_IRQ_ENABLE)
            irq_enable_reg <= reg_wdata[`EVT_WIDTH-1:0];
         config_reg <= config_next;
         irq_status_reg <= irq_status_next;
         alarm_log_reg <= alarm_log_next;
         // Only a reset, which stands for power-off, forgets the Z pass.
         if (encoder_z_pulse)
            z_passed_reg <= 1'b1;
         reg_rdata <= rdata_next;
         zero_speed_flag <= zero_speed_next;
         overspeed_alarm <= overspeed_next;
         servo_on_main_off_alarm <= servo_on_alarm_next;
         bus_voltage_drop_alarm <= bus_drop_next;
         home_position_allowed <= home_allowed_next;
         alarm_log_erase <= erase_now;
         irq <= |(irq_status_next & irq_enable_reg);
      end
   end

endmodule

// File: verification/servo_cond_chk.sv
// Port checker for the speed and alarm condition block.
`timescale 1ns/1ps
module servo_cond_chk
#(
   parameter MAX_SPEED = 16'h0BB8
)
(
   input wire        clk_sys,
   input wire        reset_n,
   input wire [15:0] motor_speed,
   input wire        ready_on_cmd,
   input wire        servo_on_cmd,
   input wire        main_circuit_on,
   input wire        bus_undervoltage,
   input wire        power_on_pulse,
   input wire        zero_speed_flag,
   input wire        overspeed_alarm,
   input wire        servo_on_main_off_alarm,
   input wire        bus_voltage_drop_alarm,
   input wire        alarm_log_erase
);
   localparam int CEIL = MAX_SPEED * 120 / 100;
   default clocking @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   zero_rest_a:
      assert property (motor_speed == 16'h0000 |=> zero_speed_flag)
      else $error("zero speed flag low at rest");
   zero_far_a:
      assert property (motor_speed > 10020 |=> !zero_speed_flag)
      else $error("zero speed flag high above any range");
   ovs_ceil_a:
      assert property (motor_speed > CEIL |=> overspeed_alarm)
      else $error("overspeed missed above ceiling");
   son_both_a:
      assert property (!main_circuit_on && servo_on_cmd && ready_on_cmd
         && !bus_undervoltage |=> servo_on_main_off_alarm)
      else $error("servo on alarm missed");
   son_idle_a:
      assert property (!servo_on_cmd && !bus_undervoltage
         |=> !servo_on_main_off_alarm)
      else $error("servo on alarm without command");
   drop_fast_a:
      assert property (bus_undervoltage && motor_speed > 16'h0032
         |=> bus_voltage_drop_alarm)
      else $error("bus drop missed at speed");
   drop_none_a:
      assert property (!bus_undervoltage |=> !bus_voltage_drop_alarm)
      else $error("bus drop without undervoltage");
   erase_cause_a:
      assert property (alarm_log_erase |-> $past(power_on_pulse))
      else $error("log erase without power on");
   erase_once_a:
      assert property (alarm_log_erase |=> !alarm_log_erase)
      else $error("log erase longer than one cycle");
   cover property (alarm_log_erase);
   cover property (servo_on_main_off_alarm && bus_undervoltage);
   cover property ($fell(zero_speed_flag));
endmodule
bind servo_speed_alarm_condition_logic servo_cond_chk
   #(.MAX_SPEED(MAX_SPEED)) i_servo_cond_chk (.*);

// File: verification/motion_ctl_model.sv
// Motion controller model issuing ready-on and servo-on commands.
`timescale 1ns/1ps
module motion_ctl_model
(
   input  wire clk_sys,
   input  wire reset_n,
   input  wire want_ready,
   input  wire want_servo,
   output reg  ready_on_cmd,
   output reg  servo_on_cmd
);
   // Commands drop during reset so no alarm is raised before release.
   always @(posedge clk_sys or negedge reset_n)
      if (!reset_n)
         {ready_on_cmd, servo_on_cmd} <= 2'h0;
      else
         {ready_on_cmd, servo_on_cmd} <= {want_ready, want_servo};
endmodule

// File: verification/servo_speed_alarm_condition_logic_bench.sv
// Self-checking bench for the speed and alarm condition block.
`timescale 1ns/1ps
module servo_speed_alarm_condition_logic_bench;
   logic        clk_sys = 0, reset_n = 0, reg_write = 0, reg_read = 0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, expq[$];
   logic [15:0] motor_speed = 16'h0000;
   logic        z = 0, want_ready = 0, want_servo = 0, main_on = 1;
   logic        uv = 0, pwr = 0, rd_wait = 0;
   wire  [31:0] reg_rdata;
   wire         ready_on_cmd, servo_on_cmd, zsf, ovs, son, drop, home;
   wire         erase, irq;
   int          mismatches = 0, total_checks = 0, cyc = 0, i, s;
   logic [15:0] sp [5] = '{16'h0000, 16'h0046, 16'h0047, 16'h0046, 16'h0032};
   always #20 clk_sys = ~clk_sys;
   motion_ctl_model i_motion_ctl_model (.clk_sys(clk_sys), .reset_n(reset_n),
      .want_ready(want_ready), .want_servo(want_servo),
      .ready_on_cmd(ready_on_cmd), .servo_on_cmd(servo_on_cmd));
   servo_speed_alarm_condition_logic i_servo_speed_alarm_condition_logic (
      .clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .motor_speed(motor_speed),
      .encoder_z_pulse(z), .ready_on_cmd(ready_on_cmd),
      .servo_on_cmd(servo_on_cmd), .main_circuit_on(main_on),
      .bus_undervoltage(uv), .power_on_pulse(pwr), .zero_speed_flag(zsf),
      .overspeed_alarm(ovs), .servo_on_main_off_alarm(son),
      .bus_voltage_drop_alarm(drop), .home_position_allowed(home),
      .alarm_log_erase(erase), .irq(irq));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("wrong value at %0t: %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task automatic step(input int n);
      repeat (n) @(posedge clk_sys);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      {reg_write, reg_addr, reg_wdata} <= {1'b1, a, d};
      @(posedge clk_sys);
      reg_write <= 1'b0;
   endtask
   // The read data are compared one cycle later by the watcher below.
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      @(posedge clk_sys);
      {reg_read, reg_addr} <= {1'b1, a};
      expq.push_back(e);
      @(posedge clk_sys);
      reg_read <= 1'b0;
   endtask
   task automatic pwr_pulse(input logic e);
      pwr <= 1'b1;
      @(posedge clk_sys);
      pwr <= 1'b0;
      @(posedge clk_sys);
      chk(erase, e);
   endtask
   always @(posedge clk_sys)
   begin
      if (rd_wait)
         chk(reg_rdata, expq.pop_front());
      rd_wait <= reg_read;
      cyc++;
      if (cyc == 3000)
      begin
         mismatches++;
         test_done();
      end
   end
   initial
   begin
      s = $urandom(32'h44525B7B);
      sp[0] = $urandom_range(50, 0);
      step(5);
      reset_n <= 1'b1;
      rd(8'h00, 32'h32);
      rd(8'h08, 32'h0);
      rd(8'h20, 32'h0E10);
      rd(8'hFC, 32'h0);
      wr(8'h00, 32'h4E20);
      rd(8'h00, 32'h2710);
      wr(8'h00, 32'h32);
      for (i = 0; i < 5; i++)
      begin
         motor_speed <= sp[i];
         rd(8'h0C, {31'h0, 1'(5'h13 >> i)});
      end
      $display("zero speed test done");
      motor_speed <= 16'h2725;
      wr(8'h14, 32'h1);
      rd(8'h0C, 32'h2);
      chk(irq, 1'b1);
      wr(8'h04, 32'h1388);
      rd(8'h20, 32'h0E10);
      wr(8'h04, 32'h03E8);
      rd(8'h20, 32'h03E8);
      motor_speed <= 16'h03E9;
      rd(8'h0C, 32'h2);
      motor_speed <= 16'h0000;
      step(2);
      wr(8'h18, 32'hF);
      rd(8'h10, 32'h0);
      chk(irq, 1'b0);
      $display("overspeed test done");
      wr(8'h08, 32'h1);
      rd(8'h0C, 32'h9);
      wr(8'h08, 32'h0);
      z <= 1'b1;
      rd(8'h0C, 32'h5);
      z <= 1'b0;
      step(2);
      rd(8'h0C, 32'hD);
      chk(home, 1'b1);
      $display("home test done");
      main_on <= 1'b0;
      for (i = 0; i < 2; i++)
      begin
         wr(8'h08, i * 2);
         want_servo <= 1'b1;
         step(3);
         chk(son, i[0]);
         want_ready <= 1'b1;
         step(3);
         chk(son, 1'b1);
         {want_servo, want_ready} <= 2'h0;
         step(3);
      end
      main_on <= 1'b1;
      for (i = 0; i < 4; i++)
      begin
         wr(8'h08, {i[1], 2'h0});
         motor_speed <= i[0] ? $urandom_range(1000, 51) : 16'h0032;
         uv <= 1'b1;
         step(3);
         chk(son, i[1] & ~i[0]);
         chk(drop, !(i[1] && !i[0]));
         uv <= 1'b0;
      end
      motor_speed <= 16'h0000;
      $display("power alarm test done");
      wr(8'h08, 32'h8);
      rd(8'h1C, 32'h7);
      pwr_pulse(1'b1);
      rd(8'h08, 32'h0);
      rd(8'h1C, 32'h0);
      rd(8'h10, 32'hE);
      pwr_pulse(1'b0);
      $display("log erase test done");
      step(2);
      test_done();
   end
endmodule
